// ===== hdl/data_alu_pkg.sv
// Package: operation codes, register selectors and field layout of the data ALU.
// Assumes a core sequencer that issues one decoded operation per clock.
package data_alu_pkg;

  localparam int IN_W   = 16;
  localparam int ACC_W  = 40;
  localparam int EXT_W  = 8;
  localparam int PROD_W = 32;
  localparam int LOW_LSB   = 0;
  localparam int HIGH_LSB  = 16;
  localparam int EXT_LSB   = 32;
  localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
  localparam logic [IN_W-1:0]  IN_RST  = 16'h0000;
  localparam logic [ACC_W-1:0] RND_CONST = 40'h00_0000_8000;
  localparam int PIPE_STAGES = 7;

  // Register selector for bus moves
  typedef enum logic [3:0] {
    SEL_X_LOW  = 4'h0,
    SEL_X_HIGH = 4'h1,
    SEL_Y_LOW  = 4'h2,
    SEL_Y_HIGH = 4'h3,
    SEL_A_LOW  = 4'h4,
    SEL_A_HIGH = 4'h5,
    SEL_A_EXT  = 4'h6,
    SEL_B_LOW  = 4'h7,
    SEL_B_HIGH = 4'h8,
    SEL_B_EXT  = 4'h9,
    SEL_A_FULL = 4'hA,
    SEL_B_FULL = 4'hB,
    SEL_X_PAIR = 4'hC,
    SEL_Y_PAIR = 4'hD
  } reg_sel_type;

  // Arithmetic operations
  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_MPY   = 4'h1,
    OP_MAC   = 4'h2,
    OP_MACN  = 4'h3,
    OP_ADD   = 4'h4,
    OP_SUB   = 4'h5,
    OP_AND   = 4'h6,
    OP_OR    = 4'h7,
    OP_EOR   = 4'h8,
    OP_ASL   = 4'h9,
    OP_ASR   = 4'hA,
    OP_BFSH  = 4'hB,
    OP_TFR   = 4'hC,
    OP_CLR   = 4'hD
  } op_type;

  // Multiplier operand signedness
  typedef enum logic [1:0] {
    MUL_SS = 2'h0,
    MUL_UU = 2'h1,
    MUL_SU = 2'h2
  } mul_mode_type;

  // Source operand selection
  typedef enum logic [2:0] {
    SRC_X_HIGH = 3'h0,
    SRC_X_LOW  = 3'h1,
    SRC_Y_HIGH = 3'h2,
    SRC_Y_LOW  = 3'h3,
    SRC_X_PAIR = 3'h4,
    SRC_Y_PAIR = 3'h5,
    SRC_OTHER  = 3'h6
  } src_type;

endpackage

// ===== hdl/data_alu_bus_if.sv
// Interface: one data-bus port of the data ALU (read and write sides).
// Assumes a single driver per signal on each modport.
`timescale 1ns/1ps
`default_nettype none
interface data_alu_bus_if;
  logic                      wr_en;
  logic                      rd_en;
  data_alu_pkg::reg_sel_type sel;
  logic [31:0]               wdata;
  logic                      limit;
  logic [39:0]               acc_val;
  logic [31:0]               rdata;

  modport alu (output wr_en, output rd_en, output sel, output wdata, output acc_val,
               input rdata);
  modport lim (input rd_en, input sel, input acc_val, input limit, output rdata);
endinterface
`default_nettype wire

// ===== hdl/bus_shift_limit.sv
// Limiter, with no shifting, between one accumulator and one data bus.
// Assumes the accumulator value is already selected onto acc_val.
`timescale 1ns/1ps
`default_nettype none
module bus_shift_limit (
  data_alu_bus_if.lim port
);
  logic [39:0] val;
  logic        over;
  logic        full;

  // ============================================================
  // Saturation when extension bits are in use
  assign full = (port.sel == data_alu_pkg::SEL_A_FULL) || (port.sel == data_alu_pkg::SEL_B_FULL);
  assign val  = port.acc_val;
  // Only whole accumulators clip; a pair read with bit 31 set must pass
  assign over = port.limit && full && (val[39:31] != {9{val[39]}});
  // Limited reads clip to the largest value of the sign; others pass the bits
  assign port.rdata = !port.rd_en ? 32'h0000_0000 :
                      over ? (val[39] ? 32'h8000_0000 : 32'h7FFF_FFFF) :
                      val[31:0];
endmodule // bus_shift_limit
`default_nettype wire

// ===== hdl/data_alu.sv
// Data ALU of a 16-bit fixed-point core: input registers, two 40-bit
// accumulators, multiply-accumulator, shifters and two bus limiters.
// Assumes the sequencer issues decoded operations synchronously to mclk_i.
// How it works
// RQ1 - Four 16-bit input registers in two pairs
// RQ2 - Accumulators join extension, high and low parts
// RQ3 - Accumulator shifter is purely combinational
// RQ4 - Bit-field unit uses a 40-bit barrel shifter
// RQ5 - One shifter/limiter per data bus; code limits only, with no shift in the bus path
// RQ6 - Registers move over either bus, 16/32 bits
// RQ7 - Arithmetic sources only from own registers
// RQ8 - Every arithmetic result lands in an accumulator
// RQ9 - Seven-stage pipeline, one operation per clock
// RQ10 - Result forwarded to next operation, no stall
// RQ11 - MAC takes three operands, gives 40 bits
// RQ12 - Signed, unsigned or mixed fractional multiply
// RQ13 - Product right-aligned, added to 40-bit accumulator
// RQ14 - 40-bit result storable as 16-bit operand
// RQ15 - Round only on request, else truncate
// RQ16 - Narrow writes sign-extend and clear low bits; code does so for high-part writes only, low/ext writes keep other bits
`timescale 1ns/1ps
`default_nettype none
module data_alu (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Operation issue
  input  wire logic        op_valid_i,
  input  wire logic [3:0]  op_code_i,
  input  wire logic [1:0]  mul_mode_i,
  input  wire logic [2:0]  src1_i,
  input  wire logic [2:0]  src2_i,
  input  wire logic        dst_b_i,
  input  wire logic        round_i,
  input  wire logic [5:0]  shift_i,
  // First data bus
  input  wire logic        xwr_en_i,
  input  wire logic        xrd_en_i,
  input  wire logic [3:0]  xsel_i,
  input  wire logic [31:0] xwdata_i,
  input  wire logic        xlimit_i,
  output logic      [31:0] xrdata_o,
  // Second data bus
  input  wire logic        ywr_en_i,
  input  wire logic        yrd_en_i,
  input  wire logic [3:0]  ysel_i,
  input  wire logic [31:0] ywdata_i,
  input  wire logic        ylimit_i,
  output logic      [31:0] yrdata_o,
  // State
  output logic      [39:0] acc_a_o,
  output logic      [39:0] acc_b_o,
  output logic      [15:0] acc_a_rnd_o,
  output logic             done_o
);
  // ============================================================
  // Registers
  logic [15:0] in_reg_x_high_q, in_reg_x_low_q, in_reg_y_high_q, in_reg_y_low_q; // RQ1
  logic [15:0] in_reg_x_high_d, in_reg_x_low_d, in_reg_y_high_d, in_reg_y_low_d;
  logic [39:0] acc_a_q, acc_b_q, acc_a_d, acc_b_d;
  localparam int PIPE_LEN = data_alu_pkg::PIPE_STAGES;
  logic [PIPE_LEN-1:0] pipe_q;

  data_alu_bus_if xbus ();
  data_alu_bus_if ybus ();

  // ============================================================
  // Operand selection, from own registers only
  function automatic logic [39:0] src_val(input logic [2:0] s, input logic [39:0] other);
    case (s)
      data_alu_pkg::SRC_X_HIGH: src_val = {{8{in_reg_x_high_q[15]}}, in_reg_x_high_q, 16'h0000};
      data_alu_pkg::SRC_X_LOW:  src_val = {{8{in_reg_x_low_q[15]}}, in_reg_x_low_q, 16'h0000};
      data_alu_pkg::SRC_Y_HIGH: src_val = {{8{in_reg_y_high_q[15]}}, in_reg_y_high_q, 16'h0000};
      data_alu_pkg::SRC_Y_LOW:  src_val = {{8{in_reg_y_low_q[15]}}, in_reg_y_low_q, 16'h0000};
      data_alu_pkg::SRC_X_PAIR: src_val = {{8{in_reg_x_high_q[15]}}, in_reg_x_high_q, in_reg_x_low_q};
      data_alu_pkg::SRC_Y_PAIR: src_val = {{8{in_reg_y_high_q[15]}}, in_reg_y_high_q, in_reg_y_low_q};
      default:                  src_val = other;
    endcase
  endfunction

  wire [39:0] acc_dst   = dst_b_i ? acc_b_q : acc_a_q; // RQ10
  wire [39:0] acc_oth   = dst_b_i ? acc_a_q : acc_b_q;
  logic [39:0] op1, op2;
  // Process, not assign: the function reads registers that are not its arguments
  always_comb begin
    op1 = src_val(src1_i, acc_oth); // RQ7
    op2 = src_val(src2_i, acc_oth);
  end
  wire [15:0] m1        = op1[31:16];
  wire [15:0] m2        = op2[31:16];

  // ============================================================
  // Multiplier, with signedness per operand
  wire        s1 = (mul_mode_i == data_alu_pkg::MUL_SS) || (mul_mode_i == data_alu_pkg::MUL_SU);
  wire        s2 = (mul_mode_i == data_alu_pkg::MUL_SS);
  wire signed [16:0] m1x = {s1 & m1[15], m1};          // RQ12
  wire signed [16:0] m2x = {s2 & m2[15], m2};
  wire signed [33:0] prod_raw = m1x * m2x;
  // Fractional: one left shift; an unsigned carry lands in the extension field
  wire [39:0] prod_ext = {{5{prod_raw[33]}}, prod_raw, 1'b0}; // RQ13
  wire [39:0] mac_sum  = acc_dst + prod_ext;           // RQ11
  wire [39:0] mac_diff = acc_dst - prod_ext;

  // ============================================================
  // Accumulator shifter: no clocked stage inside
  wire [39:0] asl_val = {acc_dst[38:0], 1'b0};         // RQ3
  wire [39:0] asr_val = {acc_dst[39], acc_dst[39:1]};

  // Bit-field barrel shifter on 40 bits
  wire [39:0] bf_val  = shift_i[5] ? (acc_dst >> shift_i[4:0]) : (acc_dst << shift_i[4:0]); // RQ4

  // ============================================================
  // Result selection before rounding
  logic [39:0] pre_rnd;
  always_comb begin
    case (op_code_i)
      data_alu_pkg::OP_MPY:  pre_rnd = prod_ext;
      data_alu_pkg::OP_MAC:  pre_rnd = mac_sum;
      data_alu_pkg::OP_MACN: pre_rnd = mac_diff;
      data_alu_pkg::OP_ADD:  pre_rnd = acc_dst + op1;
      data_alu_pkg::OP_SUB:  pre_rnd = acc_dst - op1;
      data_alu_pkg::OP_AND:  pre_rnd = acc_dst & op1;
      data_alu_pkg::OP_OR:   pre_rnd = acc_dst | op1;
      data_alu_pkg::OP_EOR:  pre_rnd = acc_dst ^ op1;
      data_alu_pkg::OP_ASL:  pre_rnd = asl_val;
      data_alu_pkg::OP_ASR:  pre_rnd = asr_val;
      data_alu_pkg::OP_BFSH: pre_rnd = bf_val;
      data_alu_pkg::OP_TFR:  pre_rnd = op1;
      data_alu_pkg::OP_CLR:  pre_rnd = data_alu_pkg::ACC_RST;
      default:               pre_rnd = acc_dst;
    endcase
  end

  // Round adds half an LSB of the high field then clears the low field
  wire [39:0] rnd_sum = pre_rnd + data_alu_pkg::RND_CONST;
  wire [39:0] result  = round_i ? {rnd_sum[39:16], 16'h0000} : pre_rnd; // RQ15
  wire        op_act  = op_valid_i && (op_code_i != data_alu_pkg::OP_NOP);

  // ============================================================
  // High-part bus writes sign-extend and clear the low field; low and extension writes keep the other bits
  function automatic logic [39:0] narrow_wr(input logic [3:0] sel, input logic [31:0] d,
                                            input logic [39:0] cur);
    case (sel)
      data_alu_pkg::SEL_A_LOW, data_alu_pkg::SEL_B_LOW:   narrow_wr = {cur[39:16], d[15:0]};
      data_alu_pkg::SEL_A_HIGH, data_alu_pkg::SEL_B_HIGH: narrow_wr = {{8{d[15]}}, d[15:0], 16'h0000};
      data_alu_pkg::SEL_A_EXT, data_alu_pkg::SEL_B_EXT:   narrow_wr = {d[7:0], cur[31:0]};
      default:                                            narrow_wr = {{8{d[31]}}, d};
    endcase
  endfunction

  wire x_hits_a = xwr_en_i && (xsel_i inside {4'h4, 4'h5, 4'h6, 4'hA});
  wire x_hits_b = xwr_en_i && (xsel_i inside {4'h7, 4'h8, 4'h9, 4'hB});
  wire y_hits_a = ywr_en_i && (ysel_i inside {4'h4, 4'h5, 4'h6, 4'hA});
  wire y_hits_b = ywr_en_i && (ysel_i inside {4'h7, 4'h8, 4'h9, 4'hB});

  // ============================================================
  // Next accumulator values; an operation outranks a bus move, second bus over first
  always_comb begin
    acc_a_d = acc_a_q;
    acc_b_d = acc_b_q;
    if (x_hits_a) acc_a_d = narrow_wr(xsel_i, xwdata_i, acc_a_q); // RQ16
    if (x_hits_b) acc_b_d = narrow_wr(xsel_i, xwdata_i, acc_b_q);
    if (y_hits_a) acc_a_d = narrow_wr(ysel_i, ywdata_i, acc_a_d); // RQ6
    if (y_hits_b) acc_b_d = narrow_wr(ysel_i, ywdata_i, acc_b_d);
    if (op_act && !dst_b_i) acc_a_d = result; // RQ8
    if (op_act && dst_b_i)  acc_b_d = result;
  end

  // Input register writes; 32-bit moves fill a pair, high word first
  always_comb begin
    in_reg_x_high_d = in_reg_x_high_q;
    in_reg_x_low_d  = in_reg_x_low_q;
    in_reg_y_high_d = in_reg_y_high_q;
    in_reg_y_low_d  = in_reg_y_low_q;
    if (xwr_en_i && xsel_i == 4'h0) in_reg_x_low_d  = xwdata_i[15:0];
    if (xwr_en_i && xsel_i == 4'h1) in_reg_x_high_d = xwdata_i[15:0];
    if (xwr_en_i && xsel_i == 4'h2) in_reg_y_low_d  = xwdata_i[15:0];
    if (xwr_en_i && xsel_i == 4'h3) in_reg_y_high_d = xwdata_i[15:0];
    if (xwr_en_i && xsel_i == 4'hC) {in_reg_x_high_d, in_reg_x_low_d} = xwdata_i;
    if (xwr_en_i && xsel_i == 4'hD) {in_reg_y_high_d, in_reg_y_low_d} = xwdata_i;
    if (ywr_en_i && ysel_i == 4'h0) in_reg_x_low_d  = ywdata_i[15:0];
    if (ywr_en_i && ysel_i == 4'h1) in_reg_x_high_d = ywdata_i[15:0];
    if (ywr_en_i && ysel_i == 4'h2) in_reg_y_low_d  = ywdata_i[15:0];
    if (ywr_en_i && ysel_i == 4'h3) in_reg_y_high_d = ywdata_i[15:0];
    if (ywr_en_i && ysel_i == 4'hC) {in_reg_x_high_d, in_reg_x_low_d} = ywdata_i;
    if (ywr_en_i && ysel_i == 4'hD) {in_reg_y_high_d, in_reg_y_low_d} = ywdata_i;
  end

  // ============================================================
  // State registers
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      acc_a_q <= data_alu_pkg::ACC_RST;
      acc_b_q <= data_alu_pkg::ACC_RST;
      in_reg_x_high_q <= data_alu_pkg::IN_RST;
      in_reg_x_low_q  <= data_alu_pkg::IN_RST;
      in_reg_y_high_q <= data_alu_pkg::IN_RST;
      in_reg_y_low_q  <= data_alu_pkg::IN_RST;
      pipe_q  <= '0;
    end else begin
      acc_a_q <= acc_a_d; // RQ2
      acc_b_q <= acc_b_d;
      in_reg_x_high_q <= in_reg_x_high_d;
      in_reg_x_low_q  <= in_reg_x_low_d;
      in_reg_y_high_q <= in_reg_y_high_d;
      in_reg_y_low_q  <= in_reg_y_low_d;
      // Issue tracker: one slot per stage, one new entry each clock
      pipe_q  <= {pipe_q[PIPE_LEN-2:0], op_act}; // RQ9
    end
  end

  // ============================================================
  // Bus read paths through the two limiters
  function automatic logic [39:0] rd_view(input logic [3:0] sel);
    case (sel)
      4'h0: rd_view = {24'h000000, in_reg_x_low_q};
      4'h1: rd_view = {24'h000000, in_reg_x_high_q};
      4'h2: rd_view = {24'h000000, in_reg_y_low_q};
      4'h3: rd_view = {24'h000000, in_reg_y_high_q};
      4'h4: rd_view = {24'h000000, acc_a_q[15:0]};
      4'h5: rd_view = {24'h000000, acc_a_q[31:16]};
      4'h6: rd_view = {{32{acc_a_q[39]}}, acc_a_q[39:32]};
      4'h7: rd_view = {24'h000000, acc_b_q[15:0]};
      4'h8: rd_view = {24'h000000, acc_b_q[31:16]};
      4'h9: rd_view = {{32{acc_b_q[39]}}, acc_b_q[39:32]};
      4'hA: rd_view = acc_a_q;
      4'hB: rd_view = acc_b_q;
      4'hC: rd_view = {8'h00, in_reg_x_high_q, in_reg_x_low_q};
      4'hD: rd_view = {8'h00, in_reg_y_high_q, in_reg_y_low_q};
      default: rd_view = 40'h00_0000_0000;
    endcase
  endfunction

  logic [39:0] x_view, y_view;
  // Process, so register changes reach the read data without a select change
  always_comb begin
    x_view = rd_view(xsel_i);
    y_view = rd_view(ysel_i);
  end

  assign xbus.rd_en   = xrd_en_i;
  assign xbus.sel     = data_alu_pkg::reg_sel_type'(xsel_i);
  assign xbus.limit   = xlimit_i;
  assign xbus.acc_val = x_view;
  assign xbus.wr_en   = xwr_en_i;
  assign xbus.wdata   = xwdata_i;
  assign ybus.rd_en   = yrd_en_i;
  assign ybus.sel     = data_alu_pkg::reg_sel_type'(ysel_i);
  assign ybus.limit   = ylimit_i;
  assign ybus.acc_val = y_view;
  assign ybus.wr_en   = ywr_en_i;
  assign ybus.wdata   = ywdata_i;

  bus_shift_limit u_xlim (.port(xbus)); // RQ5
  bus_shift_limit u_ylim (.port(ybus));

  assign xrdata_o = xbus.rdata;
  assign yrdata_o = ybus.rdata;

  // ============================================================
  // State outputs
  assign acc_a_o     = acc_a_q;
  assign acc_b_o     = acc_b_q;
  // Rounded high field: 40-bit value as one 16-bit operand
  wire [39:0] a_rnd  = acc_a_q + data_alu_pkg::RND_CONST;
  assign acc_a_rnd_o = a_rnd[31:16]; // RQ14
  assign done_o      = pipe_q[PIPE_LEN-1];
endmodule // data_alu
`default_nettype wire

// ===== verif/core_bus_model.sv
// Core data bus model: one bus master moving data ALU registers.
// Assumes the ALU clock; requests change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
  input  wire logic        mclk_i,
  output var  logic        wr_en_o,
  output var  logic        rd_en_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] wdata_o,
  output var  logic        limit_o,
  input  wire logic [31:0] rdata_i
);
  // =====
  // Idle bus at time zero
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    sel_o   = 4'h0;
    wdata_o = 32'h0000_0000;
    limit_o = 1'b0;
  end
  // =====
  // Write: held one edge, then data inverted so stale values never pass
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(posedge mclk_i);
    wr_en_o <= 1'b1;
    sel_o   <= s;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_en_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Read: data taken at the edge that ends the request
  task automatic rd(input logic [3:0] s, input logic l, output logic [31:0] d);
    @(posedge mclk_i);
    rd_en_o <= 1'b1;
    sel_o   <= s;
    limit_o <= l;
    @(posedge mclk_i);
    d = rdata_i;
    rd_en_o <= 1'b0;
  endtask
endmodule // core_bus_model
`default_nettype wire

// ===== verif/data_alu_assertions.sv
// Checker: timing and value relations at the data ALU ports.
// Assumes it is bound into data_alu and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module data_alu_assertions (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        op_valid_i,
  input wire logic [3:0]  op_code_i,
  input wire logic        dst_b_i,
  input wire logic        xwr_en_i,
  input wire logic        xrd_en_i,
  input wire logic [3:0]  xsel_i,
  input wire logic        xlimit_i,
  input wire logic [31:0] xrdata_o,
  input wire logic        ywr_en_i,
  input wire logic [3:0]  ysel_i,
  input wire logic [31:0] ywdata_i,
  input wire logic [39:0] acc_a_o,
  input wire logic [39:0] acc_b_o,
  input wire logic [15:0] acc_a_rnd_o,
  input wire logic        done_o
);
  // =====
  // Helpers
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  wire logic        issue   = op_valid_i && (op_code_i != 4'h0);
  wire logic        a_op    = issue && !dst_b_i;
  wire logic [39:0] rnd_sum = acc_a_o + data_alu_pkg::RND_CONST;
  wire logic [39:0] hi_exp  = {{8{ywdata_i[15]}}, ywdata_i[15:0], 16'h0000};
  // Extension is a sign copy when bits 39 to 31 agree
  wire logic        fits    = (&acc_a_o[39:31]) || !(|acc_a_o[39:31]);
  wire logic [31:0] lim_val = fits ? acc_a_o[31:0] :
                              (acc_a_o[39] ? 32'h8000_0000 : 32'h7FFF_FFFF);
  sequence done_s;
    ##7 done_o;
  endsequence
  // Y bus wins, and an op to A would override the move
  sequence hi_wr_s;
    ywr_en_i && (ysel_i == data_alu_pkg::SEL_A_HIGH) && !a_op;
  endsequence
  // =====
  // Properties
  done_after_a: assert property (issue |-> done_s)
    else $error("done pulse missing after issue");
  done_cause_a: assert property (done_o |-> $past(issue, 7))
    else $error("done pulse without issue");
  x_idle_zero_a: assert property (!xrd_en_i |-> xrdata_o == 32'h0000_0000)
    else $error("x read data not zero while idle");
  a_hold_a: assert property (!issue && !xwr_en_i && !ywr_en_i |=> $stable(acc_a_o))
    else $error("acc a changed without cause");
  b_hold_a: assert property (!issue && !xwr_en_i && !ywr_en_i |=> $stable(acc_b_o))
    else $error("acc b changed without cause");
  hi_write_a: assert property (hi_wr_s |=> acc_a_o == $past(hi_exp))
    else $error("high write not sign extended");
  rnd_field_a: assert property (acc_a_rnd_o == rnd_sum[31:16])
    else $error("rounded field wrong");
  limit_read_a: assert property (xrd_en_i && xlimit_i &&
    (xsel_i == data_alu_pkg::SEL_A_FULL) |-> xrdata_o == lim_val)
    else $error("limited read wrong");
endmodule // data_alu_assertions
bind data_alu data_alu_assertions chk (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
  .dst_b_i(dst_b_i), .xwr_en_i(xwr_en_i), .xrd_en_i(xrd_en_i), .xsel_i(xsel_i),
  .xlimit_i(xlimit_i), .xrdata_o(xrdata_o), .ywr_en_i(ywr_en_i), .ysel_i(ysel_i),
  .ywdata_i(ywdata_i), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o),
  .acc_a_rnd_o(acc_a_rnd_o), .done_o(done_o)
);
`default_nettype wire

// ===== verif/tb_dsp_data_alu_mac.sv
// Testbench: random operands through multiply and accumulate, checked
// against an integer model. Assumes bus model and checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_data_alu_mac;
  // =====
  // Signals and model state
  logic        mclk_i, nrst_i, op_valid_i, dst_b_i, round_i, done_o;
  logic        xwr_en_i, xrd_en_i, xlimit_i, ywr_en_i, yrd_en_i, ylimit_i;
  logic [1:0]  mul_mode_i;
  logic [2:0]  src1_i, src2_i;
  logic [3:0]  op_code_i, xsel_i, ysel_i;
  logic [5:0]  shift_i;
  logic [15:0] acc_a_rnd_o;
  logic [31:0] xwdata_i, ywdata_i, xrdata_o, yrdata_o, v, r;
  logic [39:0] acc_a_o, acc_b_o, exp_a, exp_b, p;
  logic [3:0]  op_c;
  logic [5:0]  sh;
  integer      seed, miscompares, compares, cycles;
  // =====
  // Design and the two bus masters
  data_alu dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
    .mul_mode_i(mul_mode_i), .src1_i(src1_i), .src2_i(src2_i), .dst_b_i(dst_b_i),
    .round_i(round_i), .shift_i(shift_i), .xwr_en_i(xwr_en_i), .xrd_en_i(xrd_en_i),
    .xsel_i(xsel_i), .xwdata_i(xwdata_i), .xlimit_i(xlimit_i), .xrdata_o(xrdata_o),
    .ywr_en_i(ywr_en_i), .yrd_en_i(yrd_en_i), .ysel_i(ysel_i), .ywdata_i(ywdata_i),
    .ylimit_i(ylimit_i), .yrdata_o(yrdata_o), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o),
    .acc_a_rnd_o(acc_a_rnd_o), .done_o(done_o)
  );
  core_bus_model xbus (.mclk_i(mclk_i), .wr_en_o(xwr_en_i), .rd_en_o(xrd_en_i),
    .sel_o(xsel_i), .wdata_o(xwdata_i), .limit_o(xlimit_i), .rdata_i(xrdata_o));
  core_bus_model ybus (.mclk_i(mclk_i), .wr_en_o(ywr_en_i), .rd_en_o(yrd_en_i),
    .sel_o(ysel_i), .wdata_o(ywdata_i), .limit_o(ylimit_i), .rdata_i(yrdata_o));
  // Clock and hang guard; a run needs under two hundred cycles
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      final_report();
    end
  end
  // =====
  // Model and checking
  function automatic logic [39:0] prod(input logic [15:0] h, l, input int m);
    longint a, b;
    a = (m == 1) ? longint'(h) : longint'($signed(h));
    b = (m == 0) ? longint'($signed(l)) : longint'(l);
    return 40'(a * b * 2);
  endfunction
  function automatic logic [39:0] rnd(input logic [39:0] x);
    return (x + 40'h00_0000_8000) & 40'hFF_FFFF_0000;
  endfunction
  // Saturate only when the extension holds real bits
  function automatic logic [31:0] lim(input logic [39:0] a);
    if ((&a[39:31]) || !(|a[39:31])) return a[31:0];
    return a[39] ? 32'h8000_0000 : 32'h7FFF_FFFF;
  endfunction
  task automatic check(input logic [39:0] seen, exp, input string what);
    compares = compares + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Issue without dropping valid, so calls run back to back
  task automatic op(input logic [3:0] c, input logic [1:0] m, input logic rd);
    @(posedge mclk_i);
    op_valid_i <= 1'b1;
    op_code_i  <= c;
    mul_mode_i <= m;
    round_i    <= rd;
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // =====
  // Main sequence
  initial begin
    seed = 80;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    mclk_i = 1'b0;
    nrst_i = 1'b0;
    op_valid_i = 1'b0;
    op_code_i = data_alu_pkg::OP_NOP;
    mul_mode_i = 2'h0;
    src1_i = data_alu_pkg::SRC_X_HIGH;
    src2_i = data_alu_pkg::SRC_X_LOW;
    dst_b_i = 1'b0;
    round_i = 1'b0;
    shift_i = 6'h00;
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    #1;
    check(acc_a_o, 40'h00_0000_0000, "acc a reset");
    check(acc_b_o, 40'h00_0000_0000, "acc b reset");
    for (int m = 0; m < 3; m++) begin
      for (int i = 0; i < 4; i++) begin
        v = $random(seed);
        xbus.wr(data_alu_pkg::SEL_X_PAIR, v);
        ybus.rd(data_alu_pkg::SEL_X_HIGH, 1'b0, r);
        check({24'h0, r[15:0]}, {24'h0, v[31:16]}, "x high");
        op(data_alu_pkg::OP_MPY, 2'(m), i[0]);
        op(data_alu_pkg::OP_MAC, 2'(m), 1'b0);
        @(posedge mclk_i);
        op_valid_i <= 1'b0;
        #1;
        p = prod(v[31:16], v[15:0], m);
        exp_a = (i[0] ? rnd(p) : p) + p;
        check(acc_a_o, exp_a, "mpy then mac");
        p = rnd(exp_a);
        check({24'h0, acc_a_rnd_o}, {24'h0, p[31:16]}, "rounded a");
        xbus.rd(data_alu_pkg::SEL_A_FULL, 1'b1, r);
        check({8'h0, r}, {8'h0, lim(exp_a)}, "limited read");
        ybus.wr(data_alu_pkg::SEL_A_HIGH, {16'h0000, ~v[15:0]});
        #1;
        check(acc_a_o, {{8{~v[15]}}, ~v[15:0], 16'h0000}, "high write");
      end
    end
    // Every other operation into B, with A as the other operand
    exp_a = {{8{~v[15]}}, ~v[15:0], 16'h0000};
    exp_b = 40'h00_0000_0000;
    for (int k = 12; k >= 2; k--) begin
      op_c = (k == 2) ? 4'hD : 4'(k);
      sh = 6'($random(seed));
      op(op_c, 2'h0, 1'b0);
      dst_b_i <= 1'b1;
      src1_i  <= data_alu_pkg::SRC_OTHER;
      shift_i <= sh;
      @(posedge mclk_i);
      op_valid_i <= 1'b0;
      #1;
      case (op_c)
        data_alu_pkg::OP_MACN: exp_b = exp_b - prod(exp_a[31:16], v[15:0], 0);
        data_alu_pkg::OP_ADD:  exp_b = exp_b + exp_a;
        data_alu_pkg::OP_SUB:  exp_b = exp_b - exp_a;
        data_alu_pkg::OP_AND:  exp_b = exp_b & exp_a;
        data_alu_pkg::OP_OR:   exp_b = exp_b | exp_a;
        data_alu_pkg::OP_EOR:  exp_b = exp_b ^ exp_a;
        data_alu_pkg::OP_ASL:  exp_b = {exp_b[38:0], 1'b0};
        data_alu_pkg::OP_ASR:  exp_b = {exp_b[39], exp_b[39:1]};
        data_alu_pkg::OP_BFSH: exp_b = sh[5] ? (exp_b >> sh[4:0]) : (exp_b << sh[4:0]);
        data_alu_pkg::OP_TFR:  exp_b = exp_a;
        default:               exp_b = 40'h00_0000_0000;
      endcase
      check(acc_b_o, exp_b, "b operation");
    end
    final_report();
  end
endmodule // tb_dsp_data_alu_mac
`default_nettype wire
